// >>> logic/bcr_pkg.sv
// Package: register map, field layout, defaults and timing of the regulator
package bcr_pkg;

  // ==========================================================
  // Bus address and register offsets
  localparam logic [6:0] BUS_ADDRESS        = 7'h12;
  localparam logic [7:0] FAULT_STATUS_ADDR  = 8'h00;
  localparam logic [7:0] REF_SELECT_ADDR    = 8'h01;
  localparam logic [7:0] FREQ_MODE_ADDR     = 8'h02;
  localparam logic [7:0] SLEW_READY_ADDR    = 8'h03;
  localparam logic [7:0] MAKER_ID_ADDR      = 8'h04;
  localparam logic [7:0] SILICON_REV_ADDR   = 8'h05;
  localparam logic [7:0] STARTUP_PROT_ADDR  = 8'h06;

  // ==========================================================
  // Power-on values and writable-bit masks
  localparam logic [7:0] FAULT_STATUS_RESET = 8'h44;
  localparam logic [7:0] REF_SELECT_RESET_A = 8'hA8;
  localparam logic [7:0] REF_SELECT_RESET_B = 8'h80;
  localparam logic [7:0] FREQ_MODE_RESET    = 8'h80;
  localparam logic [7:0] SLEW_READY_RESET   = 8'h05;
  localparam logic [7:0] STARTUP_PROT_RESET = 8'h02;
  localparam logic [7:0] REF_SELECT_WMASK   = 8'hFF;
  localparam logic [7:0] FREQ_MODE_WMASK    = 8'hE1;
  localparam logic [7:0] SLEW_READY_WMASK   = 8'h0F;
  localparam logic [7:0] STARTUP_PROT_WMASK = 8'h7F;

  // ==========================================================
  // Field positions
  localparam int REF_ENABLE_BIT  = 7;
  localparam int FREQ_LSB        = 5;
  localparam int MODE_BIT        = 0;
  localparam int RAMP_LSB        = 2;
  localparam int OVERRIDE_BIT    = 1;
  localparam int LEVEL_BIT       = 0;
  localparam int SOFT_START_LSB  = 5;
  localparam int VOUT_OVL_BIT    = 4;
  localparam int VIN_OVL_BIT     = 3;
  localparam int EDGE_RATE_BIT   = 2;
  localparam int READY_DELAY_BIT = 1;
  localparam int DISCHARGE_BIT   = 0;
  localparam int ST_CUR_LIMIT    = 7;
  localparam int ST_LOCKOUT      = 6;
  localparam int ST_VIN_OV       = 5;
  localparam int ST_VOUT_OV      = 4;
  localparam int ST_VOUT_UV      = 3;
  localparam int ST_READY        = 2;
  localparam int ST_TEMP_WARN    = 1;
  localparam int ST_OVER_TEMP    = 0;

  // ==========================================================
  // Identity fields (values arbitrary)
  localparam logic [3:0] MAKER_CODE   = 4'h7;
  localparam logic [3:0] SILICON_CODE = 4'h3;
  localparam logic [3:0] SILICON_REV  = 4'h9;

  // ==========================================================
  // Timing and serial framing
  localparam int CLK_FREQ_MHZ       = 25;
  localparam int READY_DELAY_US     = 45000;
  localparam int READY_DELAY_CYCLES = READY_DELAY_US * CLK_FREQ_MHZ;
  localparam logic [3:0] DATA_RISES  = 4'h8;
  localparam logic [3:0] FRAME_RISES = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SUB,
    ST_WDATA,
    ST_RDATA
  } bcr_state_type;

endpackage

// >>> logic/bcr_ready_delay.sv
// Module: hold-off timer between regulation and the ready indication
`timescale 1ns/10ps
`default_nettype none
module bcr_ready_delay #(
  parameter int unsigned DELAY_CYCLES = bcr_pkg::READY_DELAY_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  input  wire logic raw_ready_i,
  input  wire logic delay_en_i,
  output logic      ready_o
);
  import bcr_pkg::*;

  localparam logic [20:0] LAST_COUNT = 21'(DELAY_CYCLES - 1);

  logic [20:0] count;
  logic [20:0] next_count;
  logic        ready;
  logic        next_ready;

  // ==========================================================
  // Next state: drop at once, rise after the hold-off
  always_comb
  begin
    next_count = count;
    next_ready = ready;
    if (!raw_ready_i)
    begin
      next_count = 21'h0_0000;
      next_ready = 1'b0;
    end
    else if (!delay_en_i)
      next_ready = 1'b1;
    else if (count >= LAST_COUNT)
      next_ready = 1'b1;
    else
      next_count = count + 21'h0_0001;
  end

  // Registers; ready starts high as the status default says
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      count <= 21'h0_0000;
      ready <= 1'b1;
    end
    else
    begin
      count <= next_count;
      ready <= next_ready;
    end
  end

  assign ready_o = ready;

  delay_rise_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) $rose(ready) |-> $past(raw_ready_i)
      && (!$past(delay_en_i) || $past(count) == LAST_COUNT))
    else $error("ready rose before the hold-off ended");

  delay_drop_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) !raw_ready_i |=> !ready)
    else $error("ready held while regulation lost");

endmodule
`default_nettype wire

// >>> logic/bcr_status_flags.sv
// Module: live and latched fault flags of the status register
`timescale 1ns/10ps
`default_nettype none
module bcr_status_flags (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       current_limit_i,
  input  wire logic       lockout_i,
  input  wire logic       input_ov_i,
  input  wire logic       output_ov_i,
  input  wire logic       output_uv_i,
  input  wire logic       ready_i,
  input  wire logic       thermal_warning_i,
  input  wire logic       over_temp_i,
  input  wire logic       input_ov_latch_i,
  input  wire logic       output_ov_latch_i,
  input  wire logic       clear_i,
  output logic [7:0]      status_o
);
  import bcr_pkg::*;

  logic [7:0] status;
  logic [7:0] next_status;
  logic [3:0] event_in;
  logic [3:0] latch_en;
  logic [3:0] held;
  logic [3:0] next_flag;

  assign event_in = {input_ov_i, output_ov_i, output_uv_i, over_temp_i};
  assign latch_en = {input_ov_latch_i, output_ov_latch_i, 1'b1, 1'b1};
  assign held     = {status[ST_VIN_OV], status[ST_VOUT_OV],
                     status[ST_VOUT_UV], status[ST_OVER_TEMP]};

  // ==========================================================
  // Per flag: latched mode keeps it, a new event beats the clear
  for (genvar i = 0; i < 4; i++)
  begin : g_flag
    assign next_flag[i] = event_in[i]
                        | (latch_en[i] & held[i] & ~clear_i);
  end

  // Assemble the byte; live bits follow their inputs
  always_comb
  begin
    next_status               = 8'h00;
    next_status[ST_CUR_LIMIT] = current_limit_i;
    next_status[ST_LOCKOUT]   = lockout_i;
    next_status[ST_VIN_OV]    = next_flag[3];
    next_status[ST_VOUT_OV]   = next_flag[2];
    next_status[ST_VOUT_UV]   = next_flag[1];
    next_status[ST_READY]     = ready_i;
    next_status[ST_TEMP_WARN] = thermal_warning_i;
    next_status[ST_OVER_TEMP] = next_flag[0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      status <= FAULT_STATUS_RESET;
    else
      status <= next_status;
  end

  assign status_o = status;

  live_bits_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) ##1 (status[ST_CUR_LIMIT] == $past(current_limit_i))
     && (status[ST_TEMP_WARN] == $past(thermal_warning_i))
     && (status[ST_LOCKOUT] == $past(lockout_i)))
    else $error("live status bit does not track its input");

  ov_latch_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) status[ST_VIN_OV] && input_ov_latch_i && !clear_i
      |=> status[ST_VIN_OV])
    else $error("latched input overvoltage flag lost");

  status_reset_a: assert property (@(posedge clk_sys_i)
    srst_i |=> status == FAULT_STATUS_RESET)
    else $error("status not at its power-on value");

endmodule
`default_nettype wire

// >>> logic/bcr_regbank.sv
// Module: serial-bus register bank of the step-down regulator
// ==========================================================
// Summary of operation
// - Status bit 7 shows low-side current limit live, never latched.
// - Thermal warning bit is 1 above threshold, 0 below.
// - Lockout bit reads 1 while input lockout is active, resets to 1.
// - Seven-bit reference code; power-on code chosen by variant.
// - Reference register bit 7 enables the converter; resets to 1.
// - Three-bit frequency field in bits 7..5, default code 100.
// - Control one bit 0 picks auto light-load or forced fixed frequency.
// - Two-bit ramp rate field, power-on value 01.
// - Override bit hands the ready pin to the manual level bit.
// - Two-bit soft-start field in bits 6..5, default 00.
// - Latch selects make overvoltage flags sticky; both reset to 0.
// - Edge rate bit picks fast or slower switch edges; resets 0.
// - Delay bit holds off ready by 45 ms; resets to 1.
// - Answer only the fixed seven-bit bus address.
// - Sequential writes auto-increment; a partial last byte is dropped.
`timescale 1ns/10ps
`default_nettype none
module bcr_regbank #(
  parameter bit          VARIANT_B          = 1'b0,
  parameter int unsigned READY_DELAY_CYCLES = bcr_pkg::READY_DELAY_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic       current_limit_i,
  input  wire logic       lockout_i,
  input  wire logic       input_ov_i,
  input  wire logic       output_ov_i,
  input  wire logic       output_uv_i,
  input  wire logic       in_regulation_i,
  input  wire logic       thermal_warning_i,
  input  wire logic       over_temp_i,
  output logic            converter_enable_o,
  output logic [6:0]      reference_code_o,
  output logic [2:0]      switching_frequency_select_o,
  output logic            forced_fixed_frequency_o,
  output logic [1:0]      reference_ramp_select_o,
  output logic [1:0]      soft_start_select_o,
  output logic            switch_edge_rate_select_o,
  output logic            discharge_enable_o,
  output logic            input_ov_protect_o,
  output logic            output_ov_protect_o,
  output logic            ready_output_pin_o
);
  import bcr_pkg::*;

  localparam logic [7:0] REF_SELECT_RESET =
    VARIANT_B ? REF_SELECT_RESET_B : REF_SELECT_RESET_A;

  // ==========================================================
  // Serial engine state
  bcr_state_type state, next_state;
  logic          scl_q, sda_q;
  logic [3:0]    cnt, next_cnt;
  logic [7:0]    shift, next_shift;
  logic [7:0]    sub_addr, next_sub_addr;
  logic          rw, next_rw;
  logic          master_nack, next_master_nack;
  logic          sda_oe_n, next_sda_oe_n;
  logic          wr_stb, rd_load;
  logic [7:0]    rd_addr;
  logic          scl_rise, scl_fall;
  logic          start_seen, stop_seen;

  // Register bank state
  logic [7:0]    output_reference_select, next_ref_select;
  logic [7:0]    frequency_mode_control, next_freq_mode;
  logic [7:0]    slew_powergood_control, next_slew_ready;
  logic [7:0]    startup_protection_control, next_startup_prot;
  logic          ready_pin, next_ready_pin;
  logic [7:0]    fault_status;
  logic          auto_ready, status_clear;

  // ==========================================================
  // Read multiplexer; unmapped sub-addresses read zero
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    case (a)
      FAULT_STATUS_ADDR: read_byte = fault_status;
      REF_SELECT_ADDR:   read_byte = output_reference_select;
      FREQ_MODE_ADDR:    read_byte = frequency_mode_control;
      SLEW_READY_ADDR:   read_byte = slew_powergood_control;
      MAKER_ID_ADDR:     read_byte = {MAKER_CODE, SILICON_CODE};
      SILICON_REV_ADDR:  read_byte = {4'h0, SILICON_REV};
      STARTUP_PROT_ADDR: read_byte = startup_protection_control;
      default:           read_byte = 8'h00;
    endcase
  endfunction

  // Bus conditions; pins are taken as synchronous to the clock
  assign scl_rise   = scl_i & ~scl_q;
  assign scl_fall   = ~scl_i & scl_q;
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen  = scl_i & scl_q & ~sda_q & sda_i;
  assign rd_addr    = (state == ST_RDATA) ? 8'(sub_addr + 8'h01)
                                          : sub_addr;
  assign status_clear = rd_load && (rd_addr == FAULT_STATUS_ADDR);

  // ==========================================================
  // Serial engine: nine-rise frames, ack slot after the eighth
  always_comb
  begin
    next_state       = state;
    next_cnt         = cnt;
    next_shift       = shift;
    next_sub_addr    = sub_addr;
    next_rw          = rw;
    next_master_nack = master_nack;
    next_sda_oe_n    = sda_oe_n;
    wr_stb           = 1'b0;
    rd_load          = 1'b0;
    if (stop_seen)
    begin
      next_state    = ST_IDLE;
      next_sda_oe_n = 1'b1;
    end
    else if (start_seen)
    begin
      next_state    = ST_ADDR;
      next_cnt      = 4'h0;
      next_sda_oe_n = 1'b1;
    end
    else if (state != ST_IDLE && scl_rise)
    begin
      next_cnt = cnt + 4'h1;
      if (state != ST_RDATA && cnt < DATA_RISES)
        next_shift = {shift[6:0], sda_i};
      if (state == ST_RDATA && cnt == DATA_RISES)
        next_master_nack = sda_i;
    end
    else if (state != ST_IDLE && scl_fall)
    begin
      if (cnt == DATA_RISES)
      begin
        next_sda_oe_n = 1'b0;
        case (state)
          ST_ADDR:
          begin
            next_rw = shift[0];
            if (shift[7:1] != BUS_ADDRESS)
            begin
              next_state    = ST_IDLE;
              next_sda_oe_n = 1'b1;
            end
          end
          ST_SUB:   next_sub_addr = shift;
          ST_WDATA: wr_stb = 1'b1;
          ST_RDATA: next_sda_oe_n = 1'b1;
          default:  next_sda_oe_n = 1'b1;
        endcase
      end
      else if (cnt == FRAME_RISES)
      begin
        next_cnt      = 4'h0;
        next_sda_oe_n = 1'b1;
        case (state)
          ST_ADDR:  next_state = rw ? ST_RDATA : ST_SUB;
          ST_SUB:   next_state = ST_WDATA;
          ST_WDATA: next_sub_addr = 8'(sub_addr + 8'h01);
          ST_RDATA:
            if (master_nack)
              next_state = ST_IDLE;
            else
              next_sub_addr = 8'(sub_addr + 8'h01);
          default:  next_state = ST_IDLE;
        endcase
        if (next_state == ST_RDATA)
        begin
          rd_load       = 1'b1;
          next_shift    = read_byte(rd_addr);
          next_sda_oe_n = next_shift[7];
        end
      end
      else if (state == ST_RDATA && cnt < DATA_RISES)
      begin
        next_shift    = {shift[6:0], 1'b0};
        next_sda_oe_n = shift[6];
      end
    end
  end

  // Engine registers
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state       <= ST_IDLE;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      cnt         <= 4'h0;
      shift       <= 8'h00;
      sub_addr    <= 8'h00;
      rw          <= 1'b0;
      master_nack <= 1'b1;
      sda_oe_n    <= 1'b1;
      sda_o       <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      scl_q       <= scl_i;
      sda_q       <= sda_i;
      cnt         <= next_cnt;
      shift       <= next_shift;
      sub_addr    <= next_sub_addr;
      rw          <= next_rw;
      master_nack <= next_master_nack;
      sda_oe_n    <= next_sda_oe_n;
      sda_o       <= 1'b0;
    end
  end

  // ==========================================================
  // Register writes; masks keep reserved bits at zero
  always_comb
  begin
    next_ref_select   = output_reference_select;
    next_freq_mode    = frequency_mode_control;
    next_slew_ready   = slew_powergood_control;
    next_startup_prot = startup_protection_control;
    if (wr_stb)
    begin
      case (sub_addr)
        REF_SELECT_ADDR:   next_ref_select = shift & REF_SELECT_WMASK;
        FREQ_MODE_ADDR:    next_freq_mode = shift & FREQ_MODE_WMASK;
        SLEW_READY_ADDR:   next_slew_ready = shift & SLEW_READY_WMASK;
        STARTUP_PROT_ADDR: next_startup_prot = shift & STARTUP_PROT_WMASK;
        default:           next_ref_select = output_reference_select;
      endcase
    end
    // Manual level 1 pulls the pin low, 0 lets it go high
    if (slew_powergood_control[OVERRIDE_BIT])
      next_ready_pin = ~slew_powergood_control[LEVEL_BIT];
    else
      next_ready_pin = auto_ready;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      output_reference_select    <= REF_SELECT_RESET;
      frequency_mode_control     <= FREQ_MODE_RESET;
      slew_powergood_control     <= SLEW_READY_RESET;
      startup_protection_control <= STARTUP_PROT_RESET;
      ready_pin                  <= 1'b1;
    end
    else
    begin
      output_reference_select    <= next_ref_select;
      frequency_mode_control     <= next_freq_mode;
      slew_powergood_control     <= next_slew_ready;
      startup_protection_control <= next_startup_prot;
      ready_pin                  <= next_ready_pin;
    end
  end

  // ==========================================================
  // Fault flags and ready hold-off
  bcr_status_flags u_status (
    .clk_sys_i         (clk_sys_i),
    .srst_i            (srst_i),
    .current_limit_i   (current_limit_i),
    .lockout_i         (lockout_i),
    .input_ov_i        (input_ov_i),
    .output_ov_i       (output_ov_i),
    .output_uv_i       (output_uv_i),
    .ready_i           (auto_ready),
    .thermal_warning_i (thermal_warning_i),
    .over_temp_i       (over_temp_i),
    .input_ov_latch_i  (startup_protection_control[VIN_OVL_BIT]),
    .output_ov_latch_i (startup_protection_control[VOUT_OVL_BIT]),
    .clear_i           (status_clear),
    .status_o          (fault_status)
  );

  bcr_ready_delay #(.DELAY_CYCLES (READY_DELAY_CYCLES)) u_ready (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .raw_ready_i (in_regulation_i),
    .delay_en_i  (startup_protection_control[READY_DELAY_BIT]),
    .ready_o     (auto_ready)
  );

  // Field outputs straight from the register flops
  assign sda_oe_n_o                   = sda_oe_n;
  assign converter_enable_o           = output_reference_select[REF_ENABLE_BIT];
  assign reference_code_o             = output_reference_select[6:0];
  assign switching_frequency_select_o = frequency_mode_control[FREQ_LSB +: 3];
  assign forced_fixed_frequency_o     = frequency_mode_control[MODE_BIT];
  assign reference_ramp_select_o      = slew_powergood_control[RAMP_LSB +: 2];
  assign soft_start_select_o          = startup_protection_control[SOFT_START_LSB +: 2];
  assign switch_edge_rate_select_o    = startup_protection_control[EDGE_RATE_BIT];
  assign discharge_enable_o           = startup_protection_control[DISCHARGE_BIT];
  assign input_ov_protect_o           = fault_status[ST_VIN_OV];
  assign output_ov_protect_o          = fault_status[ST_VOUT_OV];
  assign ready_output_pin_o           = ready_pin;

  // ==========================================================
  // Checks
  addr_ack_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) state == ST_ADDR && scl_fall && cnt == DATA_RISES
      && shift[7:1] == BUS_ADDRESS && !start_seen && !stop_seen
      |=> !sda_oe_n_o && state == ST_ADDR)
    else $error("own address not acknowledged");
  addr_foreign_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) state == ST_ADDR && scl_fall && cnt == DATA_RISES
      && shift[7:1] != BUS_ADDRESS && !start_seen && !stop_seen
      |=> sda_oe_n_o && state == ST_IDLE)
    else $error("foreign address answered");
  seq_step_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) state == ST_WDATA && scl_fall
      && cnt == FRAME_RISES && !start_seen && !stop_seen
      |=> sub_addr == 8'($past(sub_addr) + 8'h01))
    else $error("sequential write did not advance");
  enable_write_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) wr_stb && sub_addr == REF_SELECT_ADDR
      |=> converter_enable_o == $past(shift[7]))
    else $error("enable bit not stored");
  reserved_zero_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) frequency_mode_control[4:1] == 4'h0
      && slew_powergood_control[7:4] == 4'h0
      && startup_protection_control[7] == 1'b0)
    else $error("reserved bit became set");
  manual_pin_a: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) slew_powergood_control[OVERRIDE_BIT]
      |=> ready_output_pin_o == !$past(slew_powergood_control[LEVEL_BIT]))
    else $error("ready pin ignores manual level");
endmodule
`default_nettype wire

// >>> testbench/bcr_i2c_master.sv
// Bus master model that drives the serial register port
`timescale 1ns/10ps
`default_nettype none
module bcr_i2c_master (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ==========================================================
  // Idle bus: both lines released high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One phase held three clocks, so the slave sees every level
  task automatic ph(input logic c, input logic d);
    @(posedge clk_sys_i);
    scl_o <= c;
    sda_o <= d;
    repeat (2) @(posedge clk_sys_i);
  endtask
  // Start or repeated start: data falls with clock high
  task automatic start();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // Stop: data rises with clock high
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // Data moves only in the low phase, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, sda_o);
    ph(1'b0, b);
    ph(1'b1, b);
    r = sda_i;
  endtask
  // Byte MSB first plus the ninth bit; a 1 releases the line
  task automatic xfer(input logic [7:0] b, input logic ak,
                      output logic [7:0] r, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(ak, nak);
  endtask
endmodule
`default_nettype wire

// >>> testbench/bcr_regbank_tb.sv
// Self-checking bench for the regulator register bank
`timescale 1ns/10ps
`default_nettype none
module bcr_regbank_tb;
  import bcr_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [7:0] ev = 8'h44;
  wire  logic [20:0] q;
  wire  logic scl, sda_m, sda_q, oe_n;
  wire  logic sda_w = sda_m & (oe_n | sda_q);
  int         fail_count = 0;
  int         comparisons = 0;
  logic [7:0] r;
  logic       a;
  logic [2:0] fq [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  // ==========================================================
  // Clock, master model and design; ev is in status bit order
  always #20 clk_sys_i = ~clk_sys_i;
  bcr_i2c_master m (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl),
    .sda_o(sda_m));
  bcr_regbank #(.READY_DELAY_CYCLES(20)) dut (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_q),
    .sda_oe_n_o(oe_n), .current_limit_i(ev[7]), .lockout_i(ev[6]),
    .input_ov_i(ev[5]), .output_ov_i(ev[4]), .output_uv_i(ev[3]),
    .in_regulation_i(ev[2]), .thermal_warning_i(ev[1]),
    .over_temp_i(ev[0]), .converter_enable_o(q[20]),
    .reference_code_o(q[19:13]), .switching_frequency_select_o(q[12:10]),
    .forced_fixed_frequency_o(q[9]), .reference_ramp_select_o(q[8:7]),
    .soft_start_select_o(q[6:5]), .switch_edge_rate_select_o(q[4]),
    .discharge_enable_o(q[3]), .input_ov_protect_o(q[2]),
    .output_ov_protect_o(q[1]), .ready_output_pin_o(q[0]));
  // ==========================================================
  // Compare, verdict and bus transfers
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    m.start();
    m.xfer({BUS_ADDRESS, 1'b0}, 1'b1, r, a);
    m.xfer(s, 1'b1, r, a);
    m.xfer(d, 1'b1, r, a);
    chk(a, 1'b0);
    m.stop();
  endtask
  // Sub-address write, repeated start, one byte, nack and stop
  task automatic rd(input logic [7:0] s, input logic [7:0] e);
    m.start();
    m.xfer({BUS_ADDRESS, 1'b0}, 1'b1, r, a);
    m.xfer(s, 1'b1, r, a);
    m.start();
    m.xfer({BUS_ADDRESS, 1'b1}, 1'b1, r, a);
    m.xfer(8'hFF, 1'b1, r, a);
    m.stop();
    chk(r, e);
  endtask
  // Sequential write whose trailing half byte must be dropped
  task automatic seq_partial();
    m.start();
    m.xfer({BUS_ADDRESS, 1'b0}, 1'b1, r, a);
    m.xfer(8'h01, 1'b1, r, a);
    m.xfer(8'h3F, 1'b1, r, a);
    m.xfer(8'h20, 1'b1, r, a);
    repeat (4) m.bit_io(1'b0, a);
    m.stop();
    chk(q, {8'h3F, 13'h05F8});
  endtask
  // Ready pin falls at once, rises only after the hold-off
  task automatic ready_hold();
    ev <= 8'h40;
    repeat (3) @(posedge clk_sys_i);
    chk(q[0], 1'b0);
    ev <= 8'h44;
    repeat (10) @(posedge clk_sys_i);
    chk(q[0], 1'b0);
    repeat (15) @(posedge clk_sys_i);
    chk(q[0], 1'b1);
  endtask
  // Pulse on every latchable fault; sticky flags hold, clear on read
  task automatic ov_pulse(input logic [7:0] e);
    ev <= 8'h7D;
    @(posedge clk_sys_i);
    ev <= 8'h44;
    repeat (3) @(posedge clk_sys_i);
    chk(q[2:1], e[5:4]);
    rd(8'h00, e);
  endtask
  // ==========================================================
  // Watchdog, then main sequence
  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    fail_count++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    chk(q, {8'hA8, 13'h1081});
    rd(8'h00, 8'h44);
    rd(8'h01, 8'hA8);
    rd(8'h02, 8'h80);
    rd(8'h03, 8'h05);
    rd(8'h04, {MAKER_CODE, SILICON_CODE});
    rd(8'h05, {4'h0, SILICON_REV});
    rd(8'h06, 8'h02);
    for (int i = 0; i < 7; i++)
      wr(8'(i), 8'hFF);
    rd(8'h00, 8'h44);
    rd(8'h02, 8'hE1);
    rd(8'h06, 8'h7F);
    chk(q, {8'hFF, 13'h1FF8});
    seq_partial();
    wr(8'h03, 8'h02);
    chk(q[0], 1'b1);
    wr(8'h03, 8'h04);
    ready_hold();
    ov_pulse(8'h7D);
    ev <= 8'h86;
    rd(8'h00, 8'h86);
    ev <= 8'h44;
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h02, {fq[i], 4'h0, i[0]});
      wr(8'h03, {4'h0, i[1:0], 2'h0});
      wr(8'h06, {1'b0, i[1:0], 5'h0});
      chk(q[12:5], {fq[i], i[0], i[1:0], i[1:0]});
    end
    ov_pulse(8'h4D);
    m.start();
    m.xfer({BUS_ADDRESS ^ 7'h01, 1'b0}, 1'b1, r, a);
    m.stop();
    chk(a, 1'b1);
    results();
  end
endmodule
`default_nettype wire
